// File: src/step_profile_pkg.sv
// shared constants for the adaptation step profile block
package step_profile_pkg;
  // register indices, byte address is index times four
  localparam logic [7:0] IDX_STATUS_A = 8'h02;
  localparam logic [7:0] IDX_FLAT_A = 8'h04;
  localparam logic [7:0] IDX_SSC_A = 8'h06;
  localparam logic [7:0] IDX_NS_A = 8'h07;
  localparam logic [7:0] IDX_STATUS_B = 8'h22;
  localparam logic [7:0] IDX_FLAT_B = 8'h24;
  localparam logic [7:0] IDX_SSC_B = 8'h26;
  localparam logic [7:0] IDX_NS_B = 8'h27;
  localparam logic [7:0] IDX_MODE = 8'h10;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h11;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h12;
  localparam logic [7:0] IDX_TAP = 8'h13;
  localparam logic [7:0] IDX_MU = 8'h14;
  // reset values
  localparam logic [7:0] RST_FLAT = 8'h00;
  localparam logic [2:0] RST_SSC = 3'h4;
  localparam logic [7:0] RST_NS = 8'h00;
  // detector status bit positions
  localparam int POS_NARROW = 0;
  localparam int POS_TDG = 1;
  localparam int POS_DTALK = 5;
  localparam int POS_TONE = 6;
  // interrupt status: second canceller sits above the first
  localparam int IRQ_B_BASE = 4;
  // profile shape
  localparam logic [4:0] MU_MIN_EXP = 5'h10;
  localparam logic [4:0] MU_NOMINAL_EXP = 5'h0A;
  localparam logic [10:0] FILT_LEN_NORM = 11'h200;
  localparam logic [10:0] FILT_LEN_EXT = 11'h400;
  localparam logic [9:0] SS_BASE = 10'h004;
  // tap period timing
  localparam int TAP_PERIOD_US = 125;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TAP_TICK_CYCLES = TAP_PERIOD_US * 1000 / CLK_PERIOD_NS;
  // profile region, one-hot
  typedef enum logic [2:0] {
    REGION_FLAT = 3'b001,
    REGION_NOMINAL = 3'b010,
    REGION_DECAY = 3'b100
  } region_t;
endpackage

// File: src/pin_sync3.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // pins and filtered level
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] s1_q, s2_q, s3_q; // stage chain, s1 only feeds s2
  logic [W-1:0] level_d;

  // a change counts only once stage two and three agree
  always_comb begin
    level_d = level_out;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        level_d[i] = s3_q[i];
      end
    end
  end

  // register the chain
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_out <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_out <= level_d;
    end
  end
endmodule

// File: src/step_profile.sv
// per-canceller tap walker and step-size exponent generator
`timescale 1ns/1ps
module step_profile
  import step_profile_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // tap rate and shape settings
  input wire logic tick_in,
  input wire logic ext_mode_in,
  input wire logic [7:0] flat_delay_count_in,
  input wire logic [2:0] decay_step_size_code_in,
  input wire logic [7:0] decay_step_count_in,
  // current tap and its step exponent, step = 2^-exp
  output logic [9:0] tap_out,
  output logic [4:0] mu_exp_out
);
  logic [10:0] tap_q, tap_d; // tap under evaluation
  logic [4:0] exp_q, exp_d;
  region_t region_q, region_d;
  logic [10:0] filt_len, flat_end, decay_start, into_decay;
  logic [9:0] step_len;
  logic [17:0] decay_span;
  logic [11:0] exp_sum;
  logic flat_hit, decay_hit;

  // profile shape from settings and current tap
  always_comb begin
    filt_len = ext_mode_in ? FILT_LEN_EXT : FILT_LEN_NORM;
    step_len = SS_BASE << decay_step_size_code_in; // [RULE3]
    decay_span = 18'(decay_step_count_in) * 18'(step_len);
    // oversized span starts decay at tap zero
    decay_start = (decay_span >= 18'(filt_len)) ? 11'h000 : filt_len - decay_span[10:0]; // [RULE4]
    // out-of-range flat delay just flattens the whole filter [RULE2]
    flat_end = {flat_delay_count_in, 3'h0}; // [RULE1]
    flat_hit = tap_q < flat_end;
    decay_hit = tap_q >= decay_start;
    // whole decay steps of 4*2^code taps since the decay start
    into_decay = (tap_q - decay_start) >> (4'(decay_step_size_code_in) + 4'h2); // [RULE3]
    exp_sum = 12'(MU_NOMINAL_EXP) + 12'(into_decay) + 12'h001;
    // one tap per sample tick, wrap at filter end
    tap_d = tap_q; // [RULE5]
    if (tick_in) begin
      tap_d = (tap_q >= filt_len - 11'h001) ? 11'h000 : tap_q + 11'h001;
    end
    // flat wins, then decay, else nominal
    if (flat_hit) begin
      region_d = REGION_FLAT;
      exp_d = MU_MIN_EXP; // [RULE1]
    end else if (decay_hit) begin
      region_d = REGION_DECAY;
      exp_d = (exp_sum >= 12'(MU_MIN_EXP)) ? MU_MIN_EXP : exp_sum[4:0]; // [RULE3]
    end else begin
      region_d = REGION_NOMINAL;
      exp_d = MU_NOMINAL_EXP; // [RULE7]
    end
  end

  // state registers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tap_q <= 11'h000;
      exp_q <= MU_MIN_EXP;
      region_q <= REGION_FLAT;
    end else begin
      tap_q <= tap_d;
      exp_q <= exp_d;
      region_q <= region_d;
    end
  end

  assign tap_out = tap_q[9:0];
  assign mu_exp_out = exp_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  AST_FLAT_MIN: assert property (flat_hit |=> mu_exp_out == MU_MIN_EXP) // [RULE1]
    else $error("flat tap not at minimum step");
  AST_NOMINAL_MID: assert property (!flat_hit && !decay_hit |=> mu_exp_out == MU_NOMINAL_EXP) // [RULE7]
    else $error("middle tap not at nominal step");
  AST_DECAY_START: assert property (!flat_hit && tap_q == decay_start && decay_start < filt_len && $stable(tap_q)
    |=> mu_exp_out == MU_NOMINAL_EXP + 5'h01) // [RULE4]
    else $error("decay start tap not halved once");
  AST_DECAY_HALVE: assert property (!flat_hit && decay_start < filt_len && $stable(tap_q)
    && tap_q == decay_start + {1'b0, step_len} |=> mu_exp_out == MU_NOMINAL_EXP + 5'h02) // [RULE3]
    else $error("second decay step not halved again");
  AST_TAP_RATE: assert property (tick_in && tap_q < filt_len - 11'h001 && $stable(ext_mode_in)
    |=> tap_out == $past(tap_out) + 10'h001 ##1 1'b1) // [RULE5]
    else $error("tap did not advance on tick");
  AST_TAP_HOLD: assert property (!tick_in |=> $stable(tap_out)) // [RULE5]
    else $error("tap moved without a tick");
  COV_DECAY: cover property (region_q == REGION_DECAY ##1 region_q == REGION_FLAT);
endmodule

// File: src/step_profile_top.sv
// register file, bus slave and interrupts around two step profiles
//
// How it works
// RULE1 - first flat_delay_count*8 taps use 2^-16
// RULE2 - software keeps flat delay within mode range
// RULE3 - decay halves step every 4*2^code taps
// RULE4 - decay starts at length minus count*SS
// RULE5 - each tap is one 125 us period
// RULE6 - software writes zeros to reserved code bits
// RULE7 - taps between regions use nominal step
`timescale 1ns/1ps
module step_profile_top
  import step_profile_pkg::*;
#(
  parameter int TICK_CYCLES = TAP_TICK_CYCLES // cycles per tap period
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // detector pins, first canceller
  input wire logic answer_tone_seen_a_in,
  input wire logic double_talk_seen_a_in,
  input wire logic tone_detect_group_flag_a_in,
  input wire logic narrowband_seen_a_in,
  // detector pins, second canceller
  input wire logic answer_tone_seen_b_in,
  input wire logic double_talk_seen_b_in,
  input wire logic tone_detect_group_flag_b_in,
  input wire logic narrowband_seen_b_in,
  // profile outputs
  output logic tap_tick_out,
  output logic [9:0] tap_a_out,
  output logic [4:0] mu_exp_a_out,
  output logic [9:0] tap_b_out,
  output logic [4:0] mu_exp_b_out,
  // interrupt
  output logic irq_out
);
  // bus phase tracking
  logic wr_pend_q, wr_pend_d; // write data phase in progress
  logic rd_pend_q, rd_pend_d; // read wait cycle in progress
  logic [7:0] addr_q, addr_d; // word index of the current transfer
  logic [31:0] hrdata_q, hrdata_d;
  logic take;

  // software settings per canceller
  logic [7:0] flat_a_q, flat_a_d, flat_b_q, flat_b_d;
  logic [2:0] ssc_a_q, ssc_a_d, ssc_b_q, ssc_b_d;
  logic [7:0] ns_a_q, ns_a_d, ns_b_q, ns_b_d;
  logic [1:0] mode_q, mode_d; // bit per canceller, high = extended

  // interrupt state
  logic [7:0] irq_stat_q, irq_stat_d;
  logic [7:0] irq_mask_q, irq_mask_d;
  logic irq_q, irq_d;
  logic [7:0] events;
  logic [7:0] irq_clear;

  // detector levels
  logic [7:0] det_lvl; // synchronised, first canceller low nibble
  logic [7:0] det_prev_q;
  logic [7:0] status_a, status_b;

  // tap divider
  logic [15:0] div_q, div_d;
  logic tick_q, tick_d;

  // detector pins cross into our clock here
  pin_sync3 #(
    .W(8)
  ) u_det_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .pin_in({answer_tone_seen_b_in, double_talk_seen_b_in, tone_detect_group_flag_b_in, narrowband_seen_b_in,
             answer_tone_seen_a_in, double_talk_seen_a_in, tone_detect_group_flag_a_in, narrowband_seen_a_in}),
    .level_out(det_lvl)
  );

  // one profile walker per canceller
  // walkers see registered settings, so a write acts one cycle after it lands
  step_profile u_prof_a (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .tick_in(tick_q),
    .ext_mode_in(mode_q[0]),
    .flat_delay_count_in(flat_a_q),
    .decay_step_size_code_in(ssc_a_q),
    .decay_step_count_in(ns_a_q),
    .tap_out(tap_a_out),
    .mu_exp_out(mu_exp_a_out)
  );

  step_profile u_prof_b (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .tick_in(tick_q),
    .ext_mode_in(mode_q[1]),
    .flat_delay_count_in(flat_b_q),
    .decay_step_size_code_in(ssc_b_q),
    .decay_step_count_in(ns_b_q),
    .tap_out(tap_b_out),
    .mu_exp_out(mu_exp_b_out)
  );

  // status layout: tone bit6, double talk bit5, group bit1, narrowband bit0
  // reserved status bits read back zero
  always_comb begin
    status_a = 8'h00;
    status_a[POS_NARROW] = det_lvl[0];
    status_a[POS_TDG] = det_lvl[1];
    status_a[POS_DTALK] = det_lvl[2];
    status_a[POS_TONE] = det_lvl[3];
    status_b = 8'h00;
    status_b[POS_NARROW] = det_lvl[IRQ_B_BASE];
    status_b[POS_TDG] = det_lvl[IRQ_B_BASE + 1];
    status_b[POS_DTALK] = det_lvl[IRQ_B_BASE + 2];
    status_b[POS_TONE] = det_lvl[IRQ_B_BASE + 3];
  end

  // tap period divider, one tick per sample period
  // both walkers share this tick so their taps stay in step
  always_comb begin
    tick_d = 1'b0;
    div_d = div_q + 16'h0001;
    if (div_q >= 16'(TICK_CYCLES - 1)) begin
      div_d = 16'h0000;
      tick_d = 1'b1; // [RULE5]
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tap_tick_out = tick_q;

  // bus slave: writes land in data phase, reads take one wait cycle
  // the wait cycle means a read always sees a just-finished write
  // hsize and htrans bit0 are not decoded: single whole-word transfers only
  always_comb begin
    take = hsel_in & hready_in & htrans_in[1];
    wr_pend_d = take & hwrite_in;
    rd_pend_d = take & ~hwrite_in;
    addr_d = take ? haddr_in[9:2] : addr_q;
    flat_a_d = flat_a_q;
    flat_b_d = flat_b_q;
    ssc_a_d = ssc_a_q;
    ssc_b_d = ssc_b_q;
    ns_a_d = ns_a_q;
    ns_b_d = ns_b_q;
    mode_d = mode_q;
    irq_mask_d = irq_mask_q;
    hrdata_d = hrdata_q;
    irq_clear = 8'h00;
    // write data phase
    if (wr_pend_q) begin
      case (addr_q)
        IDX_FLAT_A: flat_a_d = hwdata_in[7:0];
        IDX_FLAT_B: flat_b_d = hwdata_in[7:0];
        // only the code bits are stored, upper bits read back zero
        IDX_SSC_A: ssc_a_d = hwdata_in[2:0]; // [RULE6]
        IDX_SSC_B: ssc_b_d = hwdata_in[2:0]; // [RULE6]
        IDX_NS_A: ns_a_d = hwdata_in[7:0];
        IDX_NS_B: ns_b_d = hwdata_in[7:0];
        IDX_MODE: mode_d = hwdata_in[1:0];
        IDX_IRQ_MASK: irq_mask_d = hwdata_in[7:0];
        default: ; // read-only or unmapped, ignored
      endcase
    end
    // read wait cycle loads the answer
    if (rd_pend_q) begin
      case (addr_q)
        IDX_STATUS_A: hrdata_d = {24'h000000, status_a};
        IDX_STATUS_B: hrdata_d = {24'h000000, status_b};
        IDX_FLAT_A: hrdata_d = {24'h000000, flat_a_q};
        IDX_FLAT_B: hrdata_d = {24'h000000, flat_b_q};
        IDX_SSC_A: hrdata_d = {29'h00000000, ssc_a_q};
        IDX_SSC_B: hrdata_d = {29'h00000000, ssc_b_q};
        IDX_NS_A: hrdata_d = {24'h000000, ns_a_q};
        IDX_NS_B: hrdata_d = {24'h000000, ns_b_q};
        IDX_MODE: hrdata_d = {30'h00000000, mode_q};
        IDX_IRQ_MASK: hrdata_d = {24'h000000, irq_mask_q};
        IDX_TAP: hrdata_d = {6'h00, tap_b_out, 6'h00, tap_a_out};
        IDX_MU: hrdata_d = {19'h00000, mu_exp_b_out, 3'h0, mu_exp_a_out};
        IDX_IRQ_STAT: begin
          hrdata_d = {24'h000000, irq_stat_q};
          irq_clear = 8'hFF; // read clears
        end
        default: hrdata_d = 32'h00000000; // unmapped reads zero
      endcase
    end
  end

  // settings come up at their power-up values
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata_q <= 32'h00000000;
      flat_a_q <= RST_FLAT;
      flat_b_q <= RST_FLAT;
      ssc_a_q <= RST_SSC;
      ssc_b_q <= RST_SSC;
      ns_a_q <= RST_NS;
      ns_b_q <= RST_NS;
      mode_q <= 2'h0;
      irq_mask_q <= 8'h00;
    end else begin
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      addr_q <= addr_d;
      hrdata_q <= hrdata_d;
      flat_a_q <= flat_a_d;
      flat_b_q <= flat_b_d;
      ssc_a_q <= ssc_a_d;
      ssc_b_q <= ssc_b_d;
      ns_a_q <= ns_a_d;
      ns_b_q <= ns_b_d;
      mode_q <= mode_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // stall only during the read wait cycle
  assign hreadyout_out = ~rd_pend_q;
  assign hresp_out = 1'b0;
  assign hrdata_out = hrdata_q;

  // detector rising edges are sticky events; set beats a clearing read
  always_comb begin
    events = det_lvl & ~det_prev_q;
    irq_stat_d = (irq_stat_q & ~irq_clear) | events;
    irq_d = |(irq_stat_q & irq_mask_q);
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      // idle pins are low, so a zero start gives no false edge
      det_prev_q <= 8'h00;
      irq_stat_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      det_prev_q <= det_lvl;
      irq_stat_q <= irq_stat_d;
      irq_q <= irq_d;
    end
  end

  assign irq_out = irq_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  // tick spacing holds while TICK_CYCLES is at least nine
  AST_TICK_GAP: assert property (tick_q |=> !tick_q [*8]) // [RULE5]
    else $error("tap ticks closer than the tap period");
  AST_SSC_ZERO: assert property (rd_pend_q && (addr_q == IDX_SSC_A || addr_q == IDX_SSC_B)
    |=> hrdata_out[31:3] == 29'h00000000) // [RULE6]
    else $error("reserved code bits read nonzero");
  AST_READ_WAIT: assert property (take && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read did not answer after one wait cycle");
  AST_IRQ_LEVEL: assert property (|(irq_stat_q & irq_mask_q) |=> irq_out)
    else $error("unmasked event did not raise interrupt");
  AST_EVENT_KEPT: assert property (|events |=> (irq_stat_q & $past(events)) == $past(events))
    else $error("event lost");
  // each setting write lands at the end of its data phase
  AST_FLAT_WRITE: assert property (wr_pend_q && addr_q == IDX_FLAT_A // [RULE1]
    |=> flat_a_q == $past(hwdata_in[7:0]))
    else $error("flat delay write did not land");
  AST_NS_WRITE: assert property (wr_pend_q && addr_q == IDX_NS_B // [RULE4]
    |=> ns_b_q == $past(hwdata_in[7:0]))
    else $error("decay step count write did not land");
  AST_MODE_WRITE: assert property (wr_pend_q && addr_q == IDX_MODE // [RULE4]
    |=> mode_q == $past(hwdata_in[1:0]))
    else $error("length mode write did not land");
  // only the code bits are kept, whatever software puts above them
  AST_SSC_STORE: assert property (wr_pend_q && addr_q == IDX_SSC_A // [RULE3]
    |=> ssc_a_q == $past(hwdata_in[2:0]))
    else $error("decay step size code not stored");
  // a clearing read with no new event leaves the status empty
  AST_READ_CLEARS: assert property (rd_pend_q && addr_q == IDX_IRQ_STAT && events == 8'h00
    |=> irq_stat_q == 8'h00)
    else $error("interrupt status not cleared by read");
  // masked bits alone never raise the interrupt
  AST_IRQ_QUIET: assert property ((irq_stat_q & irq_mask_q) == 8'h00 |=> !irq_out)
    else $error("interrupt raised with nothing unmasked");
  // the divider never counts past its period
  AST_DIV_RANGE: assert property (div_q < 16'(TICK_CYCLES)) // [RULE5]
    else $error("tap divider overran its period");
  COV_IRQ: cover property (irq_out ##1 rd_pend_q && addr_q == IDX_IRQ_STAT);
  COV_WRITE_FLAT: cover property (wr_pend_q && addr_q == IDX_FLAT_A);
  COV_EXT: cover property (mode_q == 2'h3 && tick_q);
endmodule

// File: verif/adaptation_step_profile_tb.sv
// self-checking bench for the step profile register block
`timescale 1ns/1ps
module adaptation_step_profile_tb;
  import step_profile_pkg::*;
  localparam int TICK = 12; // short tap period keeps the run brief
  // bus, pins and observed outputs
  logic clk_in, sys_rst_in, hsel, hwrite, hready, hresp, tick, irq;
  logic [2:0] hsize;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [3:0] det_a, det_b; // {tone, double talk, group, narrowband}
  logic [9:0] tap_a, tap_b, prev_a, prev_b;
  logic [4:0] mu_a, mu_b;
  // profile settings mirrored by the bench
  logic [15:0] seed;
  logic [7:0] fd_a, ns_a, fd_b, ns_b;
  logic [2:0] sc_a, sc_b;
  int err_count, total_checks;

  step_profile_top #(.TICK_CYCLES(TICK)) dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .answer_tone_seen_a_in(det_a[3]), .double_talk_seen_a_in(det_a[2]),
    .tone_detect_group_flag_a_in(det_a[1]), .narrowband_seen_a_in(det_a[0]),
    .answer_tone_seen_b_in(det_b[3]), .double_talk_seen_b_in(det_b[2]),
    .tone_detect_group_flag_b_in(det_b[1]), .narrowband_seen_b_in(det_b[0]),
    .tap_tick_out(tick), .tap_a_out(tap_a), .mu_exp_a_out(mu_a),
    .tap_b_out(tap_b), .mu_exp_b_out(mu_b), .irq_out(irq)
  );

  // free-running 100 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // watchdog sized for three full profile passes plus register work
  initial begin
    repeat (60000) @(posedge clk_in);
    err_count++;
    complete_run();
  end

  // 16-bit fibonacci-style shift register for repeatable stimulus
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // status register image from the four pin levels
  function automatic logic [31:0] status_of(input logic [3:0] p);
    return {24'h0, 1'b0, p[3], p[2], 3'h0, p[1], p[0]};
  endfunction

  // expected step exponent of one tap; flat region wins over decay
  function automatic logic [4:0] exp_mu(input int tap, input int len, input int fd, input int sc, input int ns);
    int ss, start, e;
    ss = 4 << sc;
    start = (ns * ss >= len) ? 0 : len - ns * ss;
    e = (tap - start) / ss + 11;
    if (tap < fd * 8) return MU_MIN_EXP;
    if (tap < start) return MU_NOMINAL_EXP;
    return (e > 16) ? MU_MIN_EXP : 5'(e);
  endfunction

  // one comparison, reported at once on mismatch
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // hold the current phase until hready is seen high at an edge
  task wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (n >= 20) check("hready", 32'h1, 32'h0);
  endtask

  // single word transfer; entered right after a rising edge
  task bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    haddr <= {22'h0, idx, 2'h0};
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask

  // read a register and compare it
  task rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    check(name, exp, rd);
  endtask

  // load both cancellers' profile settings and read them back
  task set_cfg();
    bus(1'b1, IDX_FLAT_A, {24'h0, fd_a});
    bus(1'b1, IDX_SSC_A, {29'h0, sc_a});
    bus(1'b1, IDX_NS_A, {24'h0, ns_a});
    bus(1'b1, IDX_FLAT_B, {24'h0, fd_b});
    bus(1'b1, IDX_SSC_B, {29'h0, sc_b});
    bus(1'b1, IDX_NS_B, {24'h0, ns_b});
    rd_chk("flat_a", IDX_FLAT_A, {24'h0, fd_a});
    rd_chk("ssc_a", IDX_SSC_A, {29'h0, sc_a});
    rd_chk("ns_a", IDX_NS_A, {24'h0, ns_a});
    rd_chk("flat_b", IDX_FLAT_B, {24'h0, fd_b});
    rd_chk("ssc_b", IDX_SSC_B, {29'h0, sc_b});
    rd_chk("ns_b", IDX_NS_B, {24'h0, ns_b});
  endtask

  // follow n tap periods; first two skipped while settings settle
  task run_profile(input int n);
    int gap;
    for (int i = 0; i < n; i++) begin
      gap = 0;
      do begin
        @(posedge clk_in);
        gap++;
      end while (tick !== 1'b1 && gap < 100);
      repeat (3) @(posedge clk_in);
      if (i > 0) check("tick_gap", TICK, gap + 3);
      if (i > 1) begin
        check("tap_a", (prev_a + 1) % 512, 32'(tap_a));
        check("tap_b", (prev_b + 1) % 1024, 32'(tap_b));
        check("mu_a", exp_mu(tap_a, 512, fd_a, sc_a, ns_a), 32'(mu_a));
        check("mu_b", exp_mu(tap_b, 1024, fd_b, sc_b, ns_b), 32'(mu_b));
      end
      prev_a = tap_a;
      prev_b = tap_b;
    end
  endtask

  // verdict and end of run
  task complete_run();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // reset values table: index and power-up content
  logic [7:0] rst_idx [11] = '{8'h02, 8'h04, 8'h06, 8'h07, 8'h22, 8'h24, 8'h26, 8'h27, 8'h10, 8'h11, 8'h12};
  logic [7:0] rst_val [11] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};

  // main sequence
  initial begin
    sys_rst_in = 1'b1;
    hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0; haddr = 32'h0; hwdata = 32'h0;
    hsize = 3'h0;
    det_a = 4'h0; det_b = 4'h0; seed = 16'd43;
    err_count = 0; total_checks = 0;
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    check("irq_rst", 32'h0, 32'(irq));
    for (int i = 0; i < 11; i++) rd_chk("reset_value", rst_idx[i], {24'h0, rst_val[i]});
    check("hresp", 32'h0, 32'(hresp));
    // unmapped place: write dropped, read gives zero
    bus(1'b1, 8'h3F, 32'hFFFFFFFF);
    rd_chk("unmapped", 8'h3F, 32'h0);
    // interrupt: unmasked narrowband on first canceller
    bus(1'b1, IDX_IRQ_MASK, 32'h01);
    det_a <= 4'h1;
    repeat (10) @(posedge clk_in);
    check("irq_set", 32'h1, 32'(irq));
    rd_chk("status_a", IDX_STATUS_A, 32'h01);
    rd_chk("irq_stat", IDX_IRQ_STAT, 32'h01);
    repeat (3) @(posedge clk_in);
    check("irq_clear", 32'h0, 32'(irq));
    // masked double talk on second canceller stays silent but sticks
    det_b <= 4'h4;
    repeat (10) @(posedge clk_in);
    check("irq_masked", 32'h0, 32'(irq));
    rd_chk("irq_stat_b", IDX_IRQ_STAT, 32'h40);
    rd_chk("irq_stat_cleared", IDX_IRQ_STAT, 32'h0);
    // status is read-only: a write must not stick
    bus(1'b1, IDX_STATUS_B, 32'hFF);
    rd_chk("status_b_ro", IDX_STATUS_B, 32'h20);
    // random detector levels mirrored in both status registers
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      det_a <= seed[3:0];
      det_b <= seed[7:4];
      repeat (8) @(posedge clk_in);
      rd_chk("status_a_rnd", IDX_STATUS_A, status_of(seed[3:0]));
      rd_chk("status_b_rnd", IDX_STATUS_B, status_of(seed[7:4]));
    end
    // second canceller in extended length, three profile passes
    bus(1'b1, IDX_MODE, 32'h2);
    for (int p = 0; p < 3; p++) begin
      if (p == 0) begin
        fd_a = 8'd5; sc_a = 3'd4; ns_a = 8'd4; fd_b = 8'd3; sc_b = 3'd0; ns_b = 8'd2;
      end else if (p == 1) begin
        seed = lfsr(seed);
        fd_a = seed[7:0] % 8'd65; sc_a = seed[10:8]; ns_a = {seed[15:11], seed[2:0]};
        seed = lfsr(seed);
        fd_b = seed[15:8] % 8'd129; sc_b = seed[2:0]; ns_b = seed[7:0];
      end else begin
        // decay from tap zero, and the widest flat delay of extended mode
        fd_a = 8'd0; sc_a = 3'd7; ns_a = 8'd1; fd_b = 8'd128; sc_b = 3'd3; ns_b = 8'd255;
      end
      set_cfg();
      run_profile(1028);
      // software view of the walkers after the last tap of the pass
      rd_chk("tap_reg", IDX_TAP, {6'h00, prev_b, 6'h00, prev_a});
      rd_chk("mu_reg", IDX_MU, {19'h00000, exp_mu(prev_b, 1024, fd_b, sc_b, ns_b), 3'h0,
        exp_mu(prev_a, 512, fd_a, sc_a, ns_a)});
    end
    complete_run();
  end
endmodule
